// File: rtl/fes_core.sv
/*
  Exception detection and reporting of a numeric coprocessor beside a host.
  Tracks register-stack occupancy, sets sticky exception flags, applies the
  mask, and drives the active-low fault line to the host.
  Assumes the host only issues a command while busy_o is low, holds the mask
  stable, and reports arithmetic exceptions with arith_done_i.

// Operation
// - Per-type mask bits; masked exception completes with a default fix-up result.
// - Masked exception drives nothing to the host; only result and flag.
// - Any exception sets its status flag; no location or time recorded.
// - Unmasked exception aborts the current numeric instruction.
// - Unmasked exception drives the active-low fault line to the host.
// - Non-waiting instructions execute without any pending-exception check.
// - Pointer registers load at the start of every numeric instruction.
// - Push to occupied or pop from empty slot sets stack fault and invalid.
// - Fault line held active after hardware reset.
*/
`timescale 1ns/1ps
module fes_core #(
  parameter int PTR_W = 32
) (
  input  wire logic                       clock_i,
  input  wire logic                       reset_n_i,
  input  wire logic                       cmd_valid_i,
  input  wire fes_pkg::fes_cmd_t          cmd_i,
  input  wire logic                       cmd_push_i,
  input  wire logic                       cmd_pop_i,
  input  wire logic [PTR_W-1:0]           cmd_instr_addr_i,
  input  wire logic [PTR_W-1:0]           cmd_oper_addr_i,
  input  wire logic [fes_pkg::NUM_EXC-1:0] exc_mask_i,
  input  wire logic                       arith_done_i,
  input  wire logic [fes_pkg::NUM_EXC-1:0] arith_exc_i,
  output logic                            busy_o,
  output logic                            complete_o,
  output logic                            fixup_o,
  output logic                            abort_o,
  output logic                            fault_n_o,
  output logic [fes_pkg::NUM_EXC-1:0]     status_flags_o,
  output logic                            stack_fault_flag_o,
  output logic [fes_pkg::TOP_W-1:0]       stack_top_o,
  output logic [PTR_W-1:0]                instr_ptr_o,
  output logic [PTR_W-1:0]                oper_ptr_o
);
  import fes_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (PTR_W < 1 || PTR_W > 64) begin : g_bad_width
    $error("fes_core: PTR_W must be 1..64");
  end
  // Tag word and flag reset word are fixed-width package constants
  if (STACK_DEPTH != (1 << TOP_W) || NUM_EXC != 6) begin : g_bad_pkg
    $error("fes_core: stack depth or flag count does not fit the logic");
  end

  fes_ptr_if #(.PTR_W(PTR_W)) ptr ();

  fes_ptr_store #(.PTR_W(PTR_W)) u_ptr (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .ptr       (ptr)
  );

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  fes_state_t           state;
  logic [STACK_DEPTH-1:0] tags;
  logic [TOP_W-1:0]     top;
  logic                 start_num;
  logic                 do_clear;
  logic                 do_init;
  logic                 push_fault;
  logic                 pop_fault;
  logic                 stack_hit;
  logic [TOP_W-1:0]     push_slot;
  logic [NUM_EXC-1:0]   new_exc;
  logic [NUM_EXC-1:0]   unmasked;
  logic                 report;

  // Non-waiting commands are taken even with the fault line active
  assign start_num  = cmd_valid_i && !busy_o && cmd_i == CMD_NUMERIC;
  assign do_init    = cmd_valid_i && !busy_o && cmd_i == CMD_NOWAIT_INITIALIZE;
  assign do_clear   = do_init ||
                      (cmd_valid_i && !busy_o && cmd_i == CMD_NOWAIT_CLEAR_EXCEPTIONS);
  assign push_slot  = top - 3'h1;
  assign push_fault = cmd_push_i && tags[push_slot];
  assign pop_fault  = cmd_pop_i && !tags[top];
  assign stack_hit  = start_num && (push_fault || pop_fault);

  // Exceptions of this cycle: stack check at start, arithmetic at the end
  always_comb begin
    new_exc = '0;
    if (stack_hit) begin
      new_exc[EXC_INVALID] = 1'b1;
    end
    if (state == ST_EXEC && arith_done_i) begin
      new_exc = arith_exc_i;
    end
  end

  assign report   = stack_hit || (state == ST_EXEC && arith_done_i);
  assign unmasked = new_exc & ~exc_mask_i;

  assign ptr.capture    = start_num;
  assign ptr.instr_addr = cmd_instr_addr_i;
  assign ptr.oper_addr  = cmd_oper_addr_i;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start_num && !stack_hit) begin
            state <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (arith_done_i) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= (start_num && !stack_hit) || (state == ST_EXEC && !arith_done_i);
    end
  end

  // ----------------------------------------------------------------
  // Instruction outcome pulses
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      complete_o <= 1'b0;
      fixup_o    <= 1'b0;
      abort_o    <= 1'b0;
    end else begin
      abort_o    <= report && |unmasked;
      fixup_o    <= report && |new_exc && !(|unmasked);
      complete_o <= (report && !(|unmasked)) ||
                    (cmd_valid_i && !busy_o && cmd_i != CMD_NUMERIC);
    end
  end

  // ----------------------------------------------------------------
  // Sticky flags; a new exception wins over a clear in the same cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_flags_o     <= FLAGS_RST;
      stack_fault_flag_o <= 1'b0;
    end else begin
      status_flags_o     <= (do_clear ? FLAGS_RST : status_flags_o) | new_exc;
      stack_fault_flag_o <= (do_clear ? 1'b0 : stack_fault_flag_o) | stack_hit;
    end
  end

  // ----------------------------------------------------------------
  // Fault line to the host
  // ----------------------------------------------------------------
  // Host samples it after reset to tell the coprocessor type apart
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fault_n_o <= FAULT_N_RST;
    end else if (report && |unmasked) begin
      fault_n_o <= 1'b0;
    end else if (do_clear) begin
      fault_n_o <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Register stack occupancy
  // ----------------------------------------------------------------
  // A faulting push or pop leaves the stack untouched for the handler
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      top  <= TOP_RST;
      tags <= TAGS_RST;
    end else if (do_init) begin
      top  <= TOP_RST;
      tags <= TAGS_RST;
    end else if (start_num && !stack_hit) begin
      if (cmd_pop_i && !cmd_push_i) begin
        tags[top] <= 1'b0;
        top       <= top + 3'h1;
      end else if (cmd_push_i && !cmd_pop_i) begin
        tags[push_slot] <= 1'b1;
        top             <= push_slot;
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stack_top_o <= TOP_RST;
      instr_ptr_o <= '0;
      oper_ptr_o  <= '0;
    end else begin
      stack_top_o <= top;
      instr_ptr_o <= ptr.instr_ptr;
      oper_ptr_o  <= ptr.oper_ptr;
    end
  end
endmodule

// File: rtl/fes_pkg.sv
/*
  Shared constants and types of the numeric exception unit: exception flag
  positions, reset values, stack geometry and the instruction command codes.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package fes_pkg;

  // ----------------------------------------------------------------
  // Exception flag layout
  // ----------------------------------------------------------------
  localparam int         NUM_EXC      = 6;
  localparam int         EXC_INVALID  = 0;
  localparam int         EXC_DENORMAL = 1;
  localparam int         EXC_ZERODIV  = 2;
  localparam int         EXC_OVERFLOW = 3;
  localparam int         EXC_UNDERFLW = 4;
  localparam int         EXC_PRECISN  = 5;
  localparam logic [5:0] FLAGS_RST    = 6'h00;

  // ----------------------------------------------------------------
  // Register stack geometry and reset state
  // ----------------------------------------------------------------
  localparam int         STACK_DEPTH  = 8;
  localparam int         TOP_W        = 3;
  localparam logic [2:0] TOP_RST      = 3'h0;
  localparam logic [7:0] TAGS_RST     = 8'h00;

  // Fault line level held right after reset: active (low)
  localparam logic       FAULT_N_RST  = 1'b0;

  // ----------------------------------------------------------------
  // Instruction commands from the host interface
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_NUMERIC                  = 3'h0,
    CMD_NOWAIT_INITIALIZE        = 3'h1,
    CMD_NOWAIT_STORE_ENVIRONMENT = 3'h2,
    CMD_NOWAIT_SAVE_STATE        = 3'h3,
    CMD_NOWAIT_STORE_STATUS_WORD = 3'h4,
    CMD_NOWAIT_STORE_CONTROL     = 3'h5,
    CMD_NOWAIT_CLEAR_EXCEPTIONS  = 3'h6
  } fes_cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } fes_state_t;

endpackage

// File: rtl/fes_ptr_if.sv
/*
  Carrier between the exception unit core and its pointer store.
  Assumes both ends share one clock domain.
*/
`timescale 1ns/1ps
interface fes_ptr_if #(
  parameter int PTR_W = 32
);
  logic             capture;
  logic [PTR_W-1:0] instr_addr;
  logic [PTR_W-1:0] oper_addr;
  logic [PTR_W-1:0] instr_ptr;
  logic [PTR_W-1:0] oper_ptr;

  modport core  (output capture, output instr_addr, output oper_addr,
                 input instr_ptr, input oper_ptr);
  modport store (input capture, input instr_addr, input oper_addr,
                 output instr_ptr, output oper_ptr);
endinterface

// File: rtl/fes_ptr_store.sv
/*
  Instruction and operand pointer registers, loaded when a numeric
  instruction starts so a handler can find the failed instruction.
  Assumes capture is a one-cycle pulse in the core's clock domain.
*/
`timescale 1ns/1ps
module fes_ptr_store #(
  parameter int PTR_W = 32
) (
  input  wire logic   clock_i,
  input  wire logic   reset_n_i,
  fes_ptr_if.store    ptr
);
  import fes_pkg::*;

  // ----------------------------------------------------------------
  // Pointer capture
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ptr.instr_ptr <= '0;
      ptr.oper_ptr  <= '0;
    end else if (ptr.capture) begin
      ptr.instr_ptr <= ptr.instr_addr;
      ptr.oper_ptr  <= ptr.oper_addr;
    end
  end
endmodule

// File: sim/fes_core_asserts.sv
/* Checker for the numeric exception unit, watching top-level ports only.
   Assumes bind to fes_core; one clock, async active-low reset. */
`timescale 1ns/1ps
module fes_chk import fes_pkg::*; #(
  parameter int PTR_W = 32
) (
  input logic               clock_i,
  input logic               reset_n_i,
  input logic               cmd_valid_i,
  input fes_cmd_t           cmd_i,
  input logic               cmd_push_i,
  input logic               cmd_pop_i,
  input logic [PTR_W-1:0]   cmd_instr_addr_i,
  input logic [PTR_W-1:0]   cmd_oper_addr_i,
  input logic [NUM_EXC-1:0] exc_mask_i,
  input logic               arith_done_i,
  input logic [NUM_EXC-1:0] arith_exc_i,
  input logic               busy_o,
  input logic               complete_o,
  input logic               fixup_o,
  input logic               abort_o,
  input logic               fault_n_o,
  input logic [NUM_EXC-1:0] status_flags_o,
  input logic               stack_fault_flag_o,
  input logic [TOP_W-1:0]   stack_top_o,
  input logic [PTR_W-1:0]   instr_ptr_o,
  input logic [PTR_W-1:0]   oper_ptr_o
);
  logic [NUM_EXC-1:0] exc_q;
  logic [PTR_W-1:0]   ia_q;
  wire                acc = cmd_valid_i && !busy_o;
  wire                done = busy_o && arith_done_i;
  wire                unm = |(arith_exc_i & ~exc_mask_i);

  // Remember the cause so flags and pointers can be checked later
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      exc_q <= '0;
      ia_q  <= '0;
    end else begin
      if (done) exc_q <= arith_exc_i;
      if (acc && cmd_i == CMD_NUMERIC) ia_q <= cmd_instr_addr_i;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  AST_FAULT_CLR: assert property (
    $rose(fault_n_o) |-> $past(acc && (cmd_i == CMD_NOWAIT_INITIALIZE || cmd_i == CMD_NOWAIT_CLEAR_EXCEPTIONS), 1)
  ) else $error("fault line released without clear");
  AST_MASK_QUIET: assert property (
    done && fault_n_o && !unm |=> fault_n_o) else $error("masked exception drove fault line");
  AST_UNM_ABORT: assert property (
    done && unm |-> ##[1:2] (abort_o && !fault_n_o)) else $error("unmasked exception not signalled");
  AST_FIXUP: assert property (
    done && |arith_exc_i && !unm |-> ##[1:2] (fixup_o && complete_o)) else $error("no default result");
  AST_FLAG: assert property (
    done |-> ##[1:2] ((status_flags_o & exc_q) == exc_q)) else $error("exception flag not set");
  AST_ABORT_EXCL: assert property (
    abort_o |-> !complete_o && !fixup_o) else $error("aborted instruction completed");
  AST_NOWAIT: assert property (
    acc && cmd_i != CMD_NUMERIC |-> ##[1:2] complete_o) else $error("non-waiting command stalled");
  AST_PTR: assert property (
    acc && cmd_i == CMD_NUMERIC |-> ##[2:3] (instr_ptr_o == ia_q)) else $error("pointer not loaded");
  AST_BUSY_END: assert property (
    done |=> !busy_o) else $error("busy held after arithmetic end");
  AST_STACK: assert property (
    $rose(stack_fault_flag_o) |-> status_flags_o[EXC_INVALID]) else $error("stack fault without invalid");
endmodule

bind fes_core fes_chk #(.PTR_W(PTR_W)) fes_chk_inst (.*);

// File: sim/fes_host_model.sv
/* Host integer core model issuing coprocessor commands and arithmetic results.
   Assumes commands are spaced so the unit is idle when one is issued. */
`timescale 1ns/1ps
module fes_host_model import fes_pkg::*; (
  input  logic        clock_i,
  input  logic        busy_i,
  input  logic        fault_n_i,
  output logic        valid_o,
  output fes_cmd_t    cmd_o,
  output logic        push_o,
  output logic        pop_o,
  output logic [31:0] iaddr_o,
  output logic [31:0] oaddr_o,
  output logic        done_o,
  output logic [5:0]  exc_o
);
  int traps = 0;
  initial {valid_o, push_o, pop_o, done_o, iaddr_o, oaddr_o, exc_o} = '0;
  initial cmd_o = CMD_NUMERIC;

  task automatic issue(input fes_cmd_t c, input logic pu, po, input logic [31:0] a,
                       input logic [5:0] e, input int lat);
    int n;
    n = 0;
    if (c == CMD_NUMERIC && fault_n_i === 1'b0) begin
      traps++;
      return;
    end
    // Non-waiting codes skip the fault test above
    @(negedge clock_i);
    {cmd_o, push_o, pop_o, iaddr_o, oaddr_o, valid_o} = {c, pu, po, a, ~a, 1'b1};
    @(negedge clock_i);
    {valid_o, iaddr_o, oaddr_o} = {1'b0, ~a, a};
    while (c == CMD_NUMERIC && busy_i !== 1'b1 && n < 3) begin
      @(negedge clock_i);
      n++;
    end
    if (busy_i === 1'b1) begin
      repeat (lat) @(negedge clock_i);
      {done_o, exc_o} = {1'b1, e};
      @(negedge clock_i);
      {done_o, exc_o} = {1'b0, ~e};
    end
    repeat (3) @(negedge clock_i);
  endtask
endmodule

// File: sim/testbench.sv
/* Self-checking bench of fes_core driven through the host model.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ps
module testbench;
  import fes_pkg::*;
  logic        clock_i = 0, reset_n_i = 0, cv, pu, po, ad, s_c, s_f, s_a;
  logic [5:0]  mask = 6'h3f, ae, flags;
  logic [31:0] ia, oa, ip, op;
  fes_cmd_t    cm;
  logic        busy, comp, fix, abt, fn, sff;
  logic [2:0]  st;
  int          failures = 0, samples_checked = 0;

  fes_host_model host_inst (.clock_i, .busy_i(busy), .fault_n_i(fn), .valid_o(cv), .cmd_o(cm),
    .push_o(pu), .pop_o(po), .iaddr_o(ia), .oaddr_o(oa), .done_o(ad), .exc_o(ae));
  fes_core fes_core_inst (.clock_i, .reset_n_i, .cmd_valid_i(cv), .cmd_i(cm), .cmd_push_i(pu),
    .cmd_pop_i(po), .cmd_instr_addr_i(ia), .cmd_oper_addr_i(oa), .exc_mask_i(mask),
    .arith_done_i(ad), .arith_exc_i(ae), .busy_o(busy), .complete_o(comp), .fixup_o(fix),
    .abort_o(abt), .fault_n_o(fn), .status_flags_o(flags), .stack_fault_flag_o(sff),
    .stack_top_o(st), .instr_ptr_o(ip), .oper_ptr_o(op));

  initial forever #50 clock_i = ~clock_i;
  always @(posedge clock_i) {s_c, s_f, s_a} = {s_c | comp, s_f | fix, s_a | abt};

  task automatic chk(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic run(input fes_cmd_t c, input logic p, input logic [5:0] e, input int lat,
                     input logic u = 1'b0);
    {s_c, s_f, s_a} = 3'h0;
    host_inst.issue(c, u, p, 32'h1234_5600 + lat, e, lat);
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (6) @(negedge clock_i);
    chk("fault_in_reset", fn, 0);
    reset_n_i = 1;
    run(CMD_NUMERIC, 0, 6'h00, 0);
    chk("fault_after_reset", fn, 0);
    chk("trap_count", host_inst.traps, 1);
    run(CMD_NOWAIT_INITIALIZE, 0, 6'h00, 0);
    chk("fault_init", fn, 1);
    $display("reset test done");
    for (int i = 0; i < NUM_EXC; i++) begin
      run(CMD_NUMERIC, 0, 6'h01 << i, i);
      chk("fixup", {s_f, s_c, s_a, fn}, 4'hd);
      chk("flags", flags, 6'h01 << i);
      run(CMD_NOWAIT_CLEAR_EXCEPTIONS, 0, 6'h00, 0);
    end
    $display("masked test done");
    mask = 6'h37;
    run(CMD_NUMERIC, 0, 6'h08, 2);
    chk("abort", {s_f, s_c, s_a, fn}, 4'h2);
    chk("flags_unm", flags, 6'h08);
    chk("pointers", {ip[7:0], op[7:0]}, 16'h02fd);
    run(CMD_NUMERIC, 0, 6'h00, 0);
    chk("trap_again", host_inst.traps, 2);
    for (int c = 2; c < 6; c++) begin
      run(fes_cmd_t'(c), 0, 6'h00, 0);
      chk("nowait_done", {s_c, fn}, 2'h2);
    end
    run(CMD_NOWAIT_CLEAR_EXCEPTIONS, 0, 6'h00, 0);
    chk("fault_clear", {fn, flags}, 7'h40);
    $display("unmasked test done");
    mask = 6'h3f;
    run(CMD_NOWAIT_INITIALIZE, 0, 6'h00, 0);
    run(CMD_NUMERIC, 1, 6'h00, 0);
    chk("stack_pop_empty", {sff, flags[EXC_INVALID], fn}, 3'h7);
    run(CMD_NOWAIT_INITIALIZE, 0, 6'h00, 0);
    for (int k = 0; k < STACK_DEPTH; k++) begin
      run(CMD_NUMERIC, 0, 6'h00, 0, 1'b1);
      chk("stack_top_push", st, 3'h7 - k[2:0]);
    end
    chk("stack_push_ok", {sff, flags[EXC_INVALID]}, 2'h0);
    run(CMD_NUMERIC, 1, 6'h00, 0);
    chk("stack_top_pop", st, 3'h1);
    run(CMD_NUMERIC, 0, 6'h00, 0, 1'b1);
    run(CMD_NUMERIC, 0, 6'h00, 0, 1'b1);
    chk("stack_push_full", {sff, flags[EXC_INVALID], s_f, st}, 6'h38);
    mask = 6'h3e;
    run(CMD_NUMERIC, 0, 6'h00, 0, 1'b1);
    chk("stack_unmasked", {s_a, s_c, fn, st}, 6'h20);
    $display("stack test done");
    wrap_up();
  end

  // Whole run is near 220 cycles; this span leaves ample slack
  initial begin
    repeat (3000) @(posedge clock_i);
    failures++;
    wrap_up();
  end
endmodule
